// ---- hdl/spc_pkg.sv ----
package spc_pkg;

   // register indices, byte-wide registers at consecutive addresses
   localparam logic [2:0] ADDR_TX_CTL = 3'h0;
   localparam logic [2:0] ADDR_RX_CTL = 3'h1;
   localparam logic [2:0] ADDR_TX_DATA = 3'h2;
   localparam logic [2:0] ADDR_RX_DATA = 3'h3;

   // transmit_status_control fields
   localparam int B_CLOCK_SOURCE_SELECT = 7;
   localparam int B_TX9 = 6;
   localparam int B_TRANSMIT_ENABLE_BIT = 5;
   localparam int B_SYNC = 4;
   localparam int B_BREAK_SEND_BIT = 3;
   localparam int B_HIGH_BAUD_SELECT = 2;
   localparam int B_SHIFT_EMPTY_STATUS = 1;
   localparam int B_NINTH_TRANSMIT_BIT = 0;

   // receive_status_control fields
   localparam int B_PORT_ENABLE_BIT = 7;
   localparam int B_RX9 = 6;
   localparam int B_SINGLE_RECEIVE_ENABLE = 5;
   localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
   localparam int B_NINTH_RECEIVE_BIT = 0;

   localparam logic [7:0] TX_CTL_RESET = 8'h00;
   localparam logic [7:0] RX_CTL_RESET = 8'h00;
   localparam logic [7:0] TX_CTL_WMASK = 8'hFD;
   localparam logic [7:0] RX_CTL_WMASK = 8'hF0;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // index of the last shifted bit
   localparam logic [3:0] LAST8 = 4'h7;
   localparam logic [3:0] LAST9 = 4'h8;
   localparam logic [3:0] BRK_LAST = 4'hB;

   typedef enum logic [4:0]
   {
      SPC_IDLE = 5'h01,
      SPC_START = 5'h02,
      SPC_DATA = 5'h04,
      SPC_STOP = 5'h08,
      SPC_RECV = 5'h10
   } spc_state_t;

endpackage

// ---- hdl/spc_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none

module spc_fifo
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
)
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clear_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [CW-1:0] count, next_count;
   logic push, pull;

   assign push = in_valid_i & in_ready_o;
   assign pull = out_valid_o & out_ready_i;
   assign out_data_o = mem[rd_ptr];

   always_comb
   begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push)
         next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      if (pull)
         next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      if (push & ~pull)
         next_count = count + 1'b1;
      else if (pull & ~push)
         next_count = count - 1'b1;
      if (clear_i)
      begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count = '0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         in_ready_o <= ~clear_i & (next_count != CNT_FULL);
         out_valid_o <= next_count != '0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (push)
         mem[wr_ptr] <= in_data_i;
   end

endmodule
`default_nettype wire

// ---- hdl/spc_serial_port.sv ----
// Behaviour
// - sync bit selects synchronous, else asynchronous
// - transmit enable switches transmitter on/off
// - sync receive enables override transmit enable
// - high-baud bit picks fast or slow async rate; sync always runs fast
// - shift-empty reads one when idle, resets one
// - nine-bit select gives nine or eight bits
// - port enable clear holds port in reset
// - single receive one character; continuous keeps clocking
`timescale 1ns/100ps
`default_nettype none

module spc_serial_port
   import spc_pkg::*;
#(
   parameter logic [15:0] DIV_HIGH = 16'h0004,
   parameter logic [15:0] DIV_LOW = 16'h0010,
   parameter int FIFO_DEPTH = 32
)
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic tx_space_o,
   output logic tx_ck_o,
   output logic tx_ck_oe_o,
   input wire logic tx_ck_i,
   output logic rx_dt_o,
   output logic rx_dt_oe_o,
   input wire logic rx_dt_i
);

   logic [7:0] tx_ctl, next_tx_ctl, rx_ctl, next_rx_ctl;
   logic [7:0] rx_data, next_rx_data, next_rdata;
   logic ninth_receive_bit, next_ninth_receive_bit;
   spc_state_t state, next_state;
   logic [15:0] baud_cnt, next_baud_cnt, div;
   logic [3:0] bit_cnt, next_bit_cnt, tx_last, rx_last;
   logic [8:0] shreg, next_shreg, rx_sh, next_rx_sh;
   logic ck, next_ck, dt, next_dt, brk, next_brk, ck_prev;
   logic shift_empty_status, next_shift_empty_status;
   logic next_ck_pin, next_ck_oe, next_dt_oe;
   logic pop, brk_done, char_done;
   logic port_on, sync, master, rx_req, tx_go, baud_tick, bit_tick;
   logic fifo_valid, wr_txd;
   logic [8:0] fifo_data;

   ////////////////////////////////////////////////////////////////////////
   // mode decode

   assign port_on = rx_ctl[B_PORT_ENABLE_BIT];
   assign sync = tx_ctl[B_SYNC];
   assign master = tx_ctl[B_CLOCK_SOURCE_SELECT];
   assign rx_req = sync & (rx_ctl[B_SINGLE_RECEIVE_ENABLE] | rx_ctl[B_CONTINUOUS_RECEIVE_ENABLE]);
   assign tx_go = tx_ctl[B_TRANSMIT_ENABLE_BIT] & ~rx_req;
   // sync clocks ignore the high-baud bit
   assign div = (sync | tx_ctl[B_HIGH_BAUD_SELECT]) ? DIV_HIGH : DIV_LOW;
   assign baud_tick = baud_cnt == 16'h0000;
   // sync bits advance on the falling clock edge, own or received
   assign bit_tick = ~sync ? baud_tick :
                     master ? (baud_tick & ck) : (ck_prev & ~tx_ck_i);
   assign tx_last = brk ? BRK_LAST :
                    (tx_ctl[B_TX9] ? LAST9 : LAST8);
   assign rx_last = rx_ctl[B_RX9] ? LAST9 : LAST8;
   assign wr_txd = wr_i & (addr_i == ADDR_TX_DATA) & port_on;

   ////////////////////////////////////////////////////////////////////////
   // transmit queue, ninth bit captured with each character

   spc_fifo #(
      .WIDTH(9),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clear_i(~port_on),
      .in_valid_i(wr_txd),
      .in_data_i({tx_ctl[B_NINTH_TRANSMIT_BIT], wdata_i}),
      .in_ready_o(tx_space_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_data),
      .out_ready_i(pop)
   );

   ////////////////////////////////////////////////////////////////////////
   // shift engine

   always_comb
   begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_rx_sh = rx_sh;
      next_ck = ck;
      next_dt = dt;
      next_brk = brk;
      pop = 1'b0;
      brk_done = 1'b0;
      char_done = 1'b0;
      next_baud_cnt = (state == SPC_IDLE || baud_tick) ?
                      div - 16'h0001 : baud_cnt - 16'h0001;
      if (sync && master && state != SPC_IDLE && baud_tick)
         next_ck = ~ck;
      unique case (state)
         SPC_IDLE:
         begin
            next_ck = 1'b0;
            next_dt = 1'b1;
            next_bit_cnt = 4'h0;
            if (rx_req)
               next_state = SPC_RECV;
            else if (~sync && tx_ctl[B_BREAK_SEND_BIT] && tx_go)
            begin
               next_brk = 1'b1;
               next_dt = 1'b0;
               next_state = SPC_START;
            end
            else if (tx_go && fifo_valid)
            begin
               pop = 1'b1;
               next_shreg = fifo_data;
               next_dt = sync ? fifo_data[0] : 1'b0;
               next_state = sync ? SPC_DATA : SPC_START;
            end
         end
         SPC_START:
         begin
            if (bit_tick)
            begin
               next_state = SPC_DATA;
               next_dt = ~brk & shreg[0];
            end
         end
         SPC_DATA:
         begin
            if (bit_tick && bit_cnt == tx_last)
            begin
               next_state = sync ? SPC_IDLE : SPC_STOP;
               next_dt = 1'b1;
            end
            else if (bit_tick)
            begin
               next_bit_cnt = bit_cnt + 4'h1;
               next_shreg = {1'b0, shreg[8:1]};
               next_dt = ~brk & shreg[1];
            end
         end
         SPC_STOP:
         begin
            if (bit_tick)
            begin
               next_state = SPC_IDLE;
               next_brk = 1'b0;
               brk_done = brk;
            end
         end
         SPC_RECV:
         begin
            // enables dropped mid character: clock stops, bits discarded
            if (~rx_req)
               next_state = SPC_IDLE;
            else if (bit_tick)
            begin
               next_rx_sh = {rx_dt_i, rx_sh[8:1]};
               if (bit_cnt == rx_last)
               begin
                  char_done = 1'b1;
                  next_bit_cnt = 4'h0;
                  if (~rx_ctl[B_CONTINUOUS_RECEIVE_ENABLE])
                     next_state = SPC_IDLE;
               end
               else
                  next_bit_cnt = bit_cnt + 4'h1;
            end
         end
         default:
            next_state = SPC_IDLE;
      endcase
      if (~port_on)
      begin
         next_state = SPC_IDLE;
         next_bit_cnt = 4'h0;
         next_brk = 1'b0;
         next_ck = 1'b0;
         next_dt = 1'b1;
         pop = 1'b0;
         brk_done = 1'b0;
         char_done = 1'b0;
      end
      next_shift_empty_status = (next_state == SPC_IDLE) || (next_state == SPC_RECV);
      next_ck_pin = sync ? next_ck : next_dt;
      next_ck_oe = port_on & (~sync | master);
      next_dt_oe = port_on & sync & (next_state == SPC_DATA);
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         state <= SPC_IDLE;
         baud_cnt <= 16'h0000;
         bit_cnt <= 4'h0;
         shreg <= 9'h000;
         rx_sh <= 9'h000;
         ck <= 1'b0;
         dt <= 1'b1;
         brk <= 1'b0;
         ck_prev <= 1'b0;
         shift_empty_status <= 1'b1;
         tx_ck_o <= 1'b1;
         tx_ck_oe_o <= 1'b0;
         rx_dt_o <= 1'b1;
         rx_dt_oe_o <= 1'b0;
      end
      else
      begin
         state <= next_state;
         baud_cnt <= next_baud_cnt;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         rx_sh <= next_rx_sh;
         ck <= next_ck;
         dt <= next_dt;
         brk <= next_brk;
         ck_prev <= tx_ck_i;
         shift_empty_status <= next_shift_empty_status;
         tx_ck_o <= next_ck_pin;
         tx_ck_oe_o <= next_ck_oe;
         rx_dt_o <= next_dt;
         rx_dt_oe_o <= next_dt_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers; a software write beats a hardware clear

   always_comb
   begin
      next_tx_ctl = tx_ctl;
      next_rx_ctl = rx_ctl;
      next_rx_data = rx_data;
      next_ninth_receive_bit = ninth_receive_bit;
      next_rdata = READ_ZERO;
      if (brk_done)
         next_tx_ctl[B_BREAK_SEND_BIT] = 1'b0;
      if (char_done)
         next_rx_ctl[B_SINGLE_RECEIVE_ENABLE] = 1'b0;
      if (wr_i && addr_i == ADDR_TX_CTL)
         next_tx_ctl = wdata_i & TX_CTL_WMASK;
      if (wr_i && addr_i == ADDR_RX_CTL)
         next_rx_ctl = wdata_i & RX_CTL_WMASK;
      if (char_done)
      begin
         next_rx_data = rx_ctl[B_RX9] ? next_rx_sh[7:0] : next_rx_sh[8:1];
         next_ninth_receive_bit = rx_ctl[B_RX9] & next_rx_sh[8];
      end
      if (rd_i)
      begin
         unique case (addr_i)
            ADDR_TX_CTL:
            begin
               next_rdata = tx_ctl;
               next_rdata[B_SHIFT_EMPTY_STATUS] = shift_empty_status;
            end
            ADDR_RX_CTL:
            begin
               next_rdata = rx_ctl;
               next_rdata[B_NINTH_RECEIVE_BIT] = ninth_receive_bit;
            end
            ADDR_RX_DATA:
               next_rdata = rx_data;
            default:
               next_rdata = READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         tx_ctl <= TX_CTL_RESET;
         rx_ctl <= RX_CTL_RESET;
         rx_data <= READ_ZERO;
         ninth_receive_bit <= 1'b0;
         rdata_o <= READ_ZERO;
      end
      else
      begin
         tx_ctl <= next_tx_ctl;
         rx_ctl <= next_rx_ctl;
         rx_data <= next_rx_data;
         ninth_receive_bit <= next_ninth_receive_bit;
         rdata_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   property p_slave_no_clock;
      port_on && sync && !master |=> !tx_ck_oe_o;
   endproperty
   a_slave_no_clock: assert property (p_slave_no_clock)
      else $error("slave drives the clock pin");

   property p_transmit_enable_bit_off;
      state == SPC_IDLE && !tx_ctl[B_TRANSMIT_ENABLE_BIT] |=> state != SPC_START && shift_empty_status;
   endproperty
   a_transmit_enable_bit_off: assert property (p_transmit_enable_bit_off)
      else $error("transmit started while disabled");

   property p_rx_priority;
      port_on && state == SPC_IDLE && rx_req |=> state == SPC_RECV;
   endproperty
   a_rx_priority: assert property (p_rx_priority)
      else $error("receive enable did not win");

   property p_break_clear;
      port_on && brk && state == SPC_STOP && bit_tick
      && !(wr_i && addr_i == ADDR_TX_CTL) |=> !tx_ctl[B_BREAK_SEND_BIT] && !brk;
   endproperty
   a_break_clear: assert property (p_break_clear)
      else $error("break bit not cleared");

   property p_break_zero;
      brk && state == SPC_DATA |-> !dt;
   endproperty
   a_break_zero: assert property (p_break_zero)
      else $error("break data bit not zero");

   property p_low_rate;
      port_on && !sync && !tx_ctl[B_HIGH_BAUD_SELECT] && baud_tick
      |=> baud_cnt == DIV_LOW - 16'h0001;
   endproperty
   a_low_rate: assert property (p_low_rate)
      else $error("wrong low baud reload");

   property p_shift_empty_status_done;
      port_on && state == SPC_STOP && bit_tick |=> shift_empty_status ##1 rdata_o[B_SHIFT_EMPTY_STATUS]
      || !$past(rd_i) || $past(addr_i) != ADDR_TX_CTL;
   endproperty
   a_shift_empty_status_done: assert property (p_shift_empty_status_done)
      else $error("shift-empty not set after stop");

   property p_eight_bits;
      port_on && !sync && !brk && !tx_ctl[B_TX9] && state == SPC_DATA
      && bit_cnt == LAST8 && bit_tick |=> state == SPC_STOP && dt;
   endproperty
   a_eight_bits: assert property (p_eight_bits)
      else $error("eight-bit character length wrong");

   property p_port_off;
      !port_on |=> state == SPC_IDLE && !tx_ck_oe_o && !rx_dt_oe_o;
   endproperty
   a_port_off: assert property (p_port_off)
      else $error("disabled port still active");

   property p_single_rx;
      port_on && state == SPC_RECV && char_done && !rx_ctl[B_CONTINUOUS_RECEIVE_ENABLE]
      && !(wr_i && addr_i == ADDR_RX_CTL)
      |=> state == SPC_IDLE && !rx_ctl[B_SINGLE_RECEIVE_ENABLE];
   endproperty
   a_single_rx: assert property (p_single_rx)
      else $error("single receive did not stop");

   property p_ninth_load;
      pop |=> shreg[8] == $past(fifo_data[8]);
   endproperty
   a_ninth_load: assert property (p_ninth_load)
      else $error("ninth bit not loaded");

   c_break: cover property (brk_done);
   c_rx_char: cover property (char_done && rx_ctl[B_CONTINUOUS_RECEIVE_ENABLE]);
   c_async_char: cover property (!brk && state == SPC_STOP && bit_tick);
   c_sync_tx: cover property (sync && state == SPC_DATA && bit_tick);

endmodule
`default_nettype wire

// ---- testbench/spc_peer.sv ----
`timescale 1ns/100ps
`default_nettype none

module spc_peer
(
   input wire logic clk_i,
   input wire logic line_i,
   input wire logic rx_en_i,
   input wire logic [15:0] div_i,
   input wire logic [3:0] nb_i,
   input wire logic load_i,
   input wire logic [7:0] word_i,
   output var logic dt_o,
   output var logic [12:0] got_o,
   output var int frames_o
);
   logic [12:0] sh;
   int idx;

   initial
   begin
      frames_o = 0;
      got_o = '0;
      dt_o = 1'b1;
      idx = 8;
   end

   ////////////////////////////////////////////////////////////////////////
   // async frame capture, sampled mid-bit after the start edge
   always
   begin
      @(negedge line_i);
      if (rx_en_i)
      begin
         sh = '0;
         repeat (div_i / 2) @(posedge clk_i);
         for (int i = 0; i < nb_i; i++)
         begin
            repeat (div_i) @(posedge clk_i);
            sh[i] = line_i;
         end
         got_o = sh;
         frames_o++;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sync data, next bit after each clock rise; toggles once released
   always @(posedge line_i or posedge load_i)
   begin
      if (load_i)
      begin
         idx = 0;
         dt_o = ~dt_o;
      end
      else if (idx < 8)
      begin
         dt_o = word_i[idx];
         idx++;
      end
      else
         dt_o = ~dt_o;
   end
endmodule

`default_nettype wire

// ---- testbench/tb_spc_serial_port.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_spc_serial_port
   import spc_pkg::*;
   ;
   localparam int DL = 16;
   localparam int DH = 4;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic tx_space_o, tx_ck_o, tx_ck_oe_o, rx_dt_o, rx_dt_oe_o;
   logic p_en = 1'b1;
   logic p_ld = 1'b0;
   logic [15:0] p_div = 16'h0010;
   logic [3:0] p_nb = 4'h9;
   logic [7:0] p_word = 8'h00;
   logic p_dt;
   logic [12:0] got;
   int frames;
   int err_count = 0;
   int checks_done = 0;
   int edges = 0;
   logic oe_seen = 1'b0;
   wire logic ck_w;
   wire logic dt_w;
   logic [7:0] r, w, v;

   assign ck_w = tx_ck_oe_o ? tx_ck_o : 1'b1;
   assign dt_w = rx_dt_oe_o ? rx_dt_o : p_dt;

   always #2 clk_i = ~clk_i;
   always @(posedge ck_w) edges++;
   always @(posedge clk_i) if (rx_dt_oe_o === 1'b1) oe_seen <= 1'b1;

   spc_serial_port #(.DIV_HIGH(16'h0004), .DIV_LOW(16'h0010),
      .FIFO_DEPTH(32)) DUT
   (
      .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .tx_space_o(tx_space_o), .tx_ck_o(tx_ck_o),
      .tx_ck_oe_o(tx_ck_oe_o), .tx_ck_i(ck_w), .rx_dt_o(rx_dt_o),
      .rx_dt_oe_o(rx_dt_oe_o), .rx_dt_i(dt_w)
   );

   spc_peer PEER
   (
      .clk_i(clk_i), .line_i(ck_w), .rx_en_i(p_en), .div_i(p_div),
      .nb_i(p_nb), .load_i(p_ld), .word_i(p_word), .dt_o(p_dt),
      .got_o(got), .frames_o(frames)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string n, input logic [12:0] e,
      input logic [12:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   function automatic logic [7:0] ectl(input logic [7:0] c);
      return (c & TX_CTL_WMASK & 8'hF7) | 8'h02;
   endfunction

   function automatic logic [12:0] efr(input logic [7:0] d,
      input logic nine, input logic b9);
      return nine ? {3'b000, 1'b1, b9, d} : {4'h0, 1'b1, d};
   endfunction

   // one async frame: busy during, frame bits, control after
   task automatic frame(input logic [7:0] c, input logic [7:0] d,
      input logic [15:0] dv, input logic [3:0] n, input logic [12:0] e);
      int f;
      logic [7:0] q;
      f = frames;
      p_div <= dv;
      p_nb <= n;
      wr(ADDR_TX_CTL, c);
      if (!c[B_BREAK_SEND_BIT])
         wr(ADDR_TX_DATA, d);
      repeat (2 * dv) @(posedge clk_i);
      rd(ADDR_TX_CTL, q);
      chk("shift empty busy", 13'h0, {12'h0, q[B_SHIFT_EMPTY_STATUS]});
      for (int i = 0; i < 400 && frames == f; i++)
         @(posedge clk_i);
      chk("frame", e, got);
      repeat (2 * dv) @(posedge clk_i);
      rd(ADDR_TX_CTL, q);
      chk("tx ctl after", {5'h0, ectl(c)}, {5'h0, q});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      $display("unexpected timeout: expected done seen hang");
      end_sim();
   end

   initial
   begin
      void'($urandom(32'hB649));
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(ADDR_TX_CTL, r);
      chk("tx ctl reset", 13'h02, {5'h0, r});
      rd(ADDR_RX_CTL, r);
      chk("rx ctl reset", 13'h00, {5'h0, r});
      rd(3'h5, r);
      chk("unmapped", 13'h00, {5'h0, r});
      $display("done reset");
      for (int i = 0; i < 8; i++)
      begin
         w = 8'($urandom());
         v = 8'($urandom()) & 8'h70;
         wr(ADDR_TX_CTL, w);
         wr(ADDR_RX_CTL, v);
         rd(ADDR_TX_CTL, r);
         chk("tx ctl", {5'h0, (w & TX_CTL_WMASK) | 8'h02}, {5'h0, r});
         rd(ADDR_RX_CTL, r);
         chk("rx ctl", {5'h0, v & RX_CTL_WMASK}, {5'h0, r});
      end
      wr(ADDR_TX_CTL, 8'h00);
      wr(ADDR_RX_CTL, 8'h80);
      // fifo ready flop follows the enable one cycle later
      repeat (2) @(posedge clk_i);
      #1;
      chk("space on", 13'h1, {12'h0, tx_space_o});
      $display("done registers");
      w = 8'($urandom());
      frame(8'h20, w, DL, 4'h9, efr(w, 1'b0, 1'b0));
      w = 8'($urandom());
      frame(8'h65, w, DH, 4'hA, efr(w, 1'b1, 1'b1));
      frame(8'h28, 8'h00, DL, 4'hD, 13'h1000);
      $display("done async");
      v = 8'(frames);
      wr(ADDR_TX_CTL, 8'h00);
      wr(ADDR_TX_DATA, 8'hA5);
      repeat (300) @(posedge clk_i);
      chk("no frame", {5'h0, v}, 13'(frames));
      chk("line idle", 13'h1, {12'h0, tx_ck_o});
      wr(ADDR_RX_CTL, 8'h00);
      @(posedge clk_i);
      #1;
      chk("space off", 13'h0, {12'h0, tx_space_o});
      chk("pin off", 13'h0, {12'h0, tx_ck_oe_o});
      $display("done disable");
      p_en <= 1'b0;
      p_word <= 8'($urandom());
      wr(ADDR_TX_CTL, 8'hB0);
      p_ld <= 1'b1;
      @(posedge clk_i);
      p_ld <= 1'b0;
      edges = 0;
      wr(ADDR_RX_CTL, 8'hA0);
      r = 8'hFF;
      for (int i = 0; i < 100 && r[B_SINGLE_RECEIVE_ENABLE]; i++)
         rd(ADDR_RX_CTL, r);
      chk("single clear", 13'h0, {12'h0, r[B_SINGLE_RECEIVE_ENABLE]});
      chk("clock count", 13'h8, 13'(edges));
      chk("no transmit", 13'h0, {12'h0, oe_seen});
      chk("clock low", 13'h0, {12'h0, tx_ck_o});
      rd(ADDR_RX_DATA, r);
      chk("rx data", {5'h0, p_word}, {5'h0, r});
      $display("done sync");
      end_sim();
   end
endmodule

`default_nettype wire
